/* File: src/ide_exec.sv */
// Invalidation command executor with AXI4-Lite status and control registers
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`default_nettype none
module ide_exec
  import ide_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Command queue input
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [127:0] cmd_data,
  // Endpoint invalidation request
  output logic             ep_req_valid,
  input  wire logic        ep_req_ready,
  output logic [15:0]      ep_requester_identifier,
  output logic [63:0]      ep_addr,
  output logic [5:0]       ep_range_log2,
  output logic             ep_pid_valid,
  output logic [19:0]      ep_pid,
  input  wire logic        ep_done,
  // Interrupt entry cache and drain
  output logic             wbuf_flush_req,
  input  wire logic        wbuf_flush_done,
  output logic             iec_inv_valid,
  output logic             iec_global,
  output logic [15:0]      irq_entry_index,
  output logic [15:0]      iec_index_care,
  output logic             irq_drain_req,
  input  wire logic        irq_drain_done,
  // Status write to memory
  output logic             stat_wr_valid,
  input  wire logic        stat_wr_ready,
  output logic [63:0]      stat_wr_addr,
  output logic [31:0]      stat_wr_data,
  // Completion event
  output logic             wait_event,
  // Register bus (AXI4-Lite)
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready
);
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_EVCTL  = 8'h04;
  localparam logic [7:0] REG_CFG    = 8'h08;
  localparam logic [7:0] REG_OUTST  = 8'h0C;

  // ****************************************
  // State and registers
  // ****************************************
  ide_state_e state;
  logic [127:0] cmd;
  logic [5:0]   outstanding;
  logic         wait_done_flag;
  logic         irq_mask;
  logic         irq_pending;
  logic         write_buffer_flush_required;
  logic         honour_hint;
  logic         fence_flag;
  logic         wait_active;
  logic         aw_held, w_held;
  logic [7:0]   aw_addr;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         cmd_wait_if, cmd_wait_sw;
  logic [63:0]  wait_addr;
  logic [31:0]  wait_data;

  // Range size from lowest clear address bit at or above bit 12
  function automatic logic [5:0] range_log2(input logic [63:0] a, input logic s);
    range_log2 = 6'(PAGE_SHIFT);
    if (s) begin // see R3
      for (int i = 63; i >= PAGE_SHIFT; i--) begin
        if (!a[i]) begin
          range_log2 = 6'(i + 1);
        end
      end
    end
  endfunction : range_log2

  wire logic [3:0] cmd_type   = cmd[POS_TYPE_LO +: 4];
  wire logic       is_pid     = (cmd_type == CMD_EP_PID_INV) || (cmd[POS_TYPE_HI_EXT +: 3] != 3'h0);
  wire logic [4:0] hint       = cmd[POS_HINT_LO +: 5];
  wire logic [5:0] hint_limit = (hint == 5'h00) ? FULL_PENDING : {1'b0, hint}; // see R4
  wire logic       limit_hit  = honour_hint && (outstanding >= hint_limit); // see R5
  wire logic [3:0] im_raw     = cmd[POS_IDX_MASK_LO +: 4];
  wire logic [3:0] im         = (im_raw > 4'(IDX_MASK_MAX)) ? 4'(IDX_MASK_MAX) : im_raw;
  wire logic       wr_go      = aw_held && w_held && !s_bvalid;
  wire logic       ep_fire    = ep_req_valid && ep_req_ready;
  wire logic       stat_fire  = stat_wr_valid && stat_wr_ready;
  // Earlier work still open blocks wait completion
  wire logic       wait_clear = wait_active && (outstanding == RST_OUTSTANDING) // see R19
                                && (state != IDE_EP_ISSUE) && (state != IDE_IEC)
                                && (state != IDE_FLUSH) && (state != IDE_DRAIN);
  wire logic       wait_finish = wait_active && ((wait_clear && !cmd_wait_sw) || stat_fire);
  wire logic       set_wdone  = wait_finish && cmd_wait_if;

  assign cmd_ready = (state == IDE_IDLE) && !(wait_active && fence_flag); // see R18

  // ****************************************
  // Command sequencing
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= IDE_IDLE;
      cmd   <= '0;
    end else begin
      unique case (state)
        IDE_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd   <= cmd_data;
            state <= IDE_DECODE;
          end
        end
        IDE_DECODE: begin // see R22
          if (cmd_type == CMD_EP_INV || cmd_type == CMD_EP_PID_INV) begin
            state <= IDE_EP_ISSUE;
          end else if (cmd_type == CMD_IEC_INV) begin
            state <= write_buffer_flush_required ? IDE_FLUSH : IDE_IEC; // see R14
          end else if (cmd_type == CMD_WAIT && !wait_active) begin
            state <= IDE_IDLE; // see R20
          end else if (cmd_type == CMD_WAIT) begin
            state <= IDE_WAIT_DRAIN;
          end else begin
            state <= IDE_IDLE;
          end
        end
        IDE_EP_ISSUE: if (ep_fire) state <= IDE_IDLE;
        IDE_FLUSH:    if (wbuf_flush_done) state <= IDE_IEC;
        IDE_IEC:      state <= IDE_DRAIN;
        IDE_DRAIN:    if (irq_drain_done) state <= IDE_IDLE; // see R13
        IDE_WAIT_DRAIN: if (!wait_active) state <= IDE_DECODE;
        IDE_STATUS:   state <= IDE_IDLE;
      endcase
    end
  end

  // Endpoint request fields, held from the captured command
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ep_req_valid            <= 1'b0;
      ep_requester_identifier <= '0;
      ep_addr                 <= '0;
      ep_range_log2           <= '0;
      ep_pid_valid            <= 1'b0;
      ep_pid                  <= '0;
    end else if (state == IDE_DECODE && (cmd_type == CMD_EP_INV || cmd_type == CMD_EP_PID_INV)) begin
      ep_requester_identifier <= cmd[POS_REQ_ID_LO +: 16]; // see R1
      ep_range_log2           <= range_log2(cmd[127:64], cmd[POS_SIZE]); // see R2, see R9
      ep_addr                 <= {cmd[127:76], 12'h000}; // see R2
      ep_pid_valid            <= is_pid && !cmd[POS_GLOBAL]; // see R8
      ep_pid                  <= (is_pid && !cmd[POS_GLOBAL]) ? cmd[POS_PID_LO +: 20] : 20'h0_0000;
      ep_req_valid            <= 1'b0;
    end else if (state == IDE_EP_ISSUE) begin
      ep_req_valid <= !ep_fire && !limit_hit; // see R5
    end else begin
      ep_req_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      outstanding <= RST_OUTSTANDING;
    end else if (ep_fire && !ep_done) begin
      outstanding <= outstanding + 6'h01;
    end else if (!ep_fire && ep_done && outstanding != RST_OUTSTANDING) begin
      outstanding <= outstanding - 6'h01;
    end
  end

  // Interrupt entry cache controls
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wbuf_flush_req  <= 1'b0;
      iec_inv_valid   <= 1'b0;
      iec_global      <= 1'b0;
      irq_entry_index <= '0;
      iec_index_care  <= '0;
      irq_drain_req   <= 1'b0;
    end else begin
      wbuf_flush_req <= (state == IDE_FLUSH) && !wbuf_flush_done;
      iec_inv_valid  <= (state == IDE_IEC);
      irq_drain_req  <= (state == IDE_IEC) || ((state == IDE_DRAIN) && !irq_drain_done);
      if (state == IDE_FLUSH || (state == IDE_DECODE && cmd_type == CMD_IEC_INV)) begin
        iec_global      <= !cmd[POS_IEC_GRAN]; // see R11
        irq_entry_index <= cmd[POS_IRQ_IDX_LO +: 16];
        iec_index_care  <= 16'hFFFF << im; // see R12
      end
    end
  end

  // ****************************************
  // Wait command tracking
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wait_active <= 1'b0;
      fence_flag  <= 1'b0;
      cmd_wait_if <= 1'b0;
      cmd_wait_sw <= 1'b0;
      wait_addr   <= '0;
      wait_data   <= '0;
    end else if (state == IDE_DECODE && cmd_type == CMD_WAIT && !wait_active) begin
      wait_active <= 1'b1;
      fence_flag  <= cmd[POS_WAIT_FN];
      cmd_wait_if <= cmd[POS_WAIT_IF];
      cmd_wait_sw <= cmd[POS_WAIT_SW];
      wait_addr   <= {cmd[127:66], 2'b00};
      wait_data   <= cmd[POS_STAT_DATA +: 32];
    end else if (wait_finish) begin
      wait_active <= 1'b0;
      fence_flag  <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stat_wr_valid <= 1'b0;
      stat_wr_addr  <= '0;
      stat_wr_data  <= '0;
    end else begin
      stat_wr_valid <= stat_wr_valid ? !stat_fire : (wait_clear && cmd_wait_sw); // see R15
      stat_wr_addr  <= wait_addr;
      stat_wr_data  <= wait_data;
    end
  end

  // Completion flag, pending and event; hardware set wins over software clear
  wire logic sw_clear_wdone = wr_go && aw_addr == REG_STATUS && w_strb[0] && w_data[0];
  wire logic wdone_rise     = set_wdone && !wait_done_flag;
  wire logic mask_write     = wr_go && aw_addr == REG_EVCTL && w_strb[0];
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wait_done_flag <= RST_FLAG;
      irq_pending    <= RST_FLAG;
      irq_mask       <= 1'b1;
      wait_event     <= 1'b0;
    end else begin
      if (set_wdone) begin
        wait_done_flag <= 1'b1; // see R17
      end else if (sw_clear_wdone) begin
        wait_done_flag <= 1'b0;
      end
      if (mask_write) begin
        irq_mask <= w_data[31];
      end
      wait_event <= (wdone_rise && !irq_mask) || (mask_write && !w_data[31] && irq_pending); // see R21
      if (wdone_rise && irq_mask) begin
        irq_pending <= 1'b1; // see R21
      end else if ((mask_write && !w_data[31]) || (sw_clear_wdone && !set_wdone)) begin
        irq_pending <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign s_awready = !aw_held;
  assign s_wready  = !w_held;
  assign s_arready = !s_rvalid;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
      s_bvalid <= 1'b0;
      s_bresp  <= 2'b00;
      write_buffer_flush_required <= 1'b0;
      honour_hint <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (wr_go) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= (aw_addr > REG_OUTST || aw_addr[1:0] != 2'b00) ? 2'b10 : 2'b00;
        if (aw_addr == REG_CFG && w_strb[0]) begin
          write_buffer_flush_required <= w_data[0];
          honour_hint                 <= w_data[1];
        end
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_rvalid <= 1'b0;
      s_rdata  <= '0;
      s_rresp  <= 2'b00;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp  <= 2'b00;
      unique case (s_araddr)
        REG_STATUS: s_rdata <= {31'h0, wait_done_flag};
        REG_EVCTL:  s_rdata <= {irq_mask, irq_pending, 30'h0};
        REG_CFG:    s_rdata <= {30'h0, honour_hint, write_buffer_flush_required};
        REG_OUTST:  s_rdata <= {24'h0, wait_active, fence_flag, outstanding};
        default: begin
          s_rdata <= '0;
          s_rresp <= 2'b10;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule : ide_exec
`default_nettype wire

/* File: src/ide_pkg.sv */
// Package of constants and types for the invalidation command executor
// Overview of operation
// R1: Endpoint invalidation goes to the requester, no process ID, second-level address.
// R2: Size flag zero requests one page at address bits 63:12.
// R3: Size flag one: lowest clear bit from 12 upward sets range size.
// R4: Hint value zero means endpoint takes the full 32 pending requests.
// R5: Hint may limit requests outstanding at the endpoint; optional.
// R6: Endpoint accepts 32 pending requests; may throttle beyond its hint.
// R7: Software queues central invalidation before matching endpoint invalidation.
// R8: Global flag one covers all process IDs; zero targets given ID.
// R9: Process-ID variant uses first-level address, same range encoding.
// R10: Software queues extended central invalidation before process-ID endpoint one.
// R11: Granularity zero clears whole interrupt cache; one is index selective.
// R12: Index mask n ignores low n index bits, covering 2^n entries; the code clamps n above 4 to 4.
// R13: Interrupt cache invalidation drains already remapped queued interrupts.
// R14: Write buffer flushed first when flush requirement is reported.
// R15: Status flag set gives one 32-bit status write; else fields ignored.
// R16: Software gives a status address routed to memory only.
// R17: Completion flag set sets the wait-done status flag.
// R18: Fence flag holds later commands until the wait completes.
// R19: Wait completes only after all earlier commands have completed.
// R20: Without fence, later commands may start before the wait completes.
// R21: Already set wait-done flag raises no event; else pending, unmasked event.
// R22: Each command type is decoded and dispatched after its field checks.
`default_nettype none
package ide_pkg;
  // ****************************************
  // Command encodings and field positions
  // ****************************************
  localparam logic [3:0] CMD_EP_INV      = 4'h3;
  localparam logic [3:0] CMD_IEC_INV     = 4'h4;
  localparam logic [3:0] CMD_WAIT        = 4'h5;
  localparam logic [3:0] CMD_EP_PID_INV  = 4'h8;
  localparam int         POS_TYPE_LO     = 0;
  localparam int         POS_TYPE_HI_EXT = 9;
  localparam int         POS_IEC_GRAN    = 4;
  localparam int         POS_WAIT_IF     = 4;
  localparam int         POS_WAIT_SW     = 5;
  localparam int         POS_WAIT_FN     = 6;
  localparam int         POS_HINT_LO     = 16;
  localparam int         POS_REQ_ID_LO   = 32;
  localparam int         POS_PID_LO      = 32;
  localparam int         POS_GLOBAL      = 63;
  localparam int         POS_IDX_MASK_LO = 27;
  localparam int         POS_IRQ_IDX_LO  = 32;
  localparam int         POS_SIZE        = 64;
  localparam int         POS_STAT_DATA   = 32;
  localparam int         PAGE_SHIFT      = 12;
  localparam int         IDX_MASK_MAX    = 4;
  localparam logic [5:0] FULL_PENDING    = 6'h20;
  localparam logic [5:0] RST_OUTSTANDING = 6'h00;
  localparam logic       RST_FLAG        = 1'b0;
  typedef enum logic [2:0] {
    IDE_IDLE, IDE_DECODE, IDE_EP_ISSUE, IDE_FLUSH, IDE_IEC, IDE_DRAIN, IDE_WAIT_DRAIN, IDE_STATUS
  } ide_state_e;
endpackage : ide_pkg
`default_nettype wire

/* File: tb/ide_exec_bench.sv */
// Self-checking bench for the invalidation command executor
`default_nettype none
module ide_exec_bench
  import ide_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, srst, slow, cmd_valid, cmd_ready, ep_req_valid, ep_req_ready, ep_pid_valid, ep_done;
  logic wbuf_flush_req, wbuf_flush_done, iec_inv_valid, iec_global, irq_drain_req, irq_drain_done;
  logic stat_wr_valid, stat_wr_ready, wait_event, fl, dr;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [127:0] cmd_data;
  logic [106:0] c_ep;
  logic [95:0]  c_st;
  logic [63:0]  ep_addr, stat_wr_addr, a;
  logic [33:0]  c_iec;
  logic [31:0]  stat_wr_data, s_wdata, s_rdata, d;
  logic [19:0]  ep_pid, p;
  logic [15:0]  ep_requester_identifier, irq_entry_index, iec_index_care;
  logic [7:0]   s_awaddr, s_araddr;
  logic [5:0]   ep_range_log2, lg;
  logic [3:0]   s_wstrb, t;
  logic [1:0]   s_bresp, s_rresp, r;
  int           fail_count, comparisons, ep_cnt, iec_cnt, st_cnt, ev_cnt;
  ide_exec dut_u (.clk_sys, .srst, .cmd_valid, .cmd_ready, .cmd_data, .ep_req_valid, .ep_req_ready,
    .ep_requester_identifier, .ep_addr, .ep_range_log2, .ep_pid_valid, .ep_pid, .ep_done, .wbuf_flush_req,
    .wbuf_flush_done, .iec_inv_valid, .iec_global, .irq_entry_index, .iec_index_care, .irq_drain_req,
    .irq_drain_done, .stat_wr_valid, .stat_wr_ready, .stat_wr_addr, .stat_wr_data, .wait_event, .s_awaddr,
    .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
  ide_far_model far_u (.clk_sys, .srst, .slow, .ep_req_valid, .ep_req_ready, .ep_done, .wbuf_flush_req,
    .wbuf_flush_done, .irq_drain_req, .irq_drain_done, .stat_wr_valid, .stat_wr_ready);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ****************************************
  // Monitor, tasks and checks
  // ****************************************
  always @(posedge clk_sys) begin
    if (wbuf_flush_req) fl = 1'b1;
    if (irq_drain_req) dr = 1'b1;
    if (wait_event) ev_cnt++;
    if (ep_req_valid && ep_req_ready) begin
      ep_cnt++;
      c_ep = {ep_requester_identifier, ep_addr, ep_range_log2, ep_pid_valid, ep_pid};
    end
    if (iec_inv_valid) begin
      iec_cnt++;
      c_iec = {iec_global, irq_entry_index, iec_index_care, fl};
      fl = 1'b0;
    end
    if (stat_wr_valid && stat_wr_ready) begin
      st_cnt++;
      c_st = {stat_wr_addr, stat_wr_data};
    end
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle
  task automatic send_cmd(input logic [127:0] c);
    int n;
    n = 0;
    cmd_data  <= c;
    cmd_valid <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!cmd_ready && n < 200);
    cmd_valid <= 1'b0;
    @(posedge clk_sys);
  endtask : send_cmd
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt);
    logic ga, gw;
    {ga, gw} = 2'b00;
    s_awaddr <= ad;
    s_wdata  <= dt;
    {s_awvalid, s_wvalid, s_bready} <= 3'b111;
    do begin
      @(posedge clk_sys);
      if (!ga && s_awready) begin
        ga = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!gw && s_wready) begin
        gw = 1'b1;
        s_wvalid <= 1'b0;
      end
    end while (!(ga && gw && s_bvalid));
    s_bready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    logic g;
    g = 1'b0;
    s_araddr <= ad;
    {s_arvalid, s_rready} <= 2'b11;
    do begin
      @(posedge clk_sys);
      if (!g && s_arready) begin
        g = 1'b1;
        s_arvalid <= 1'b0;
      end
    end while (!(g && s_rvalid));
    dt = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_rd
  // Status address routed to ordinary memory
  function automatic logic [127:0] wcmd(input logic [2:0] f);
    return {62'h00_0040_0000, 2'b00, 32'hC0DE_0001, 25'h000_0000, f, CMD_WAIT};
  endfunction : wcmd
  task automatic end_sim;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  initial begin
    idle(5000);
    fail_count++;
    $display("CHECK FAILED at %0t: timeout", $time);
    end_sim();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {srst, slow, cmd_valid, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, fl, dr} = 10'h200;
    {cmd_data, s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hF;
    idle(4);
    srst <= 1'b0;
    idle(1);
    axi_rd(8'h04, d, r);
    chk(d, 32'h8000_0000);
    axi_rd(8'h40, d, r);
    chk(r, 2'b10);
    // Central cache invalidated upstream before these endpoint commands
    for (int i = 0; i < 5; i++) begin
      a  = (i == 0) ? 64'h0000_7654_3210_0ABC : (64'h0000_7654_3210_0001 | (((64'h1 << (i - 1)) - 64'h1) << 12));
      t  = (i % 2) ? CMD_EP_PID_INV : CMD_EP_INV;
      lg = (i == 0) ? 6'h0C : 6'(12 + i);
      p  = 20'h0_A5C3 + 20'(i);
      send_cmd({a, i == 3, 11'h000, p, 11'h000, 5'h00, 12'h000, t});
      idle(12);
      chk(ep_cnt, i + 1);
      chk(c_ep[26:21], lg);
      chk(c_ep[90:27] >> lg, a >> lg);
      chk(c_ep[20], t == CMD_EP_PID_INV && i != 3);
      if (t == CMD_EP_INV) chk(c_ep[106:91], p[15:0]);
      else if (i == 1) chk(c_ep[19:0], p);
    end
    axi_wr(8'h08, 32'h0000_0001);
    for (int n = 0; n < 6; n++) begin
      send_cmd({80'h0, 16'h1237, 1'b0, n[3:0], 22'h00_0000, n < 5, CMD_IEC_INV});
      idle(12);
      chk(iec_cnt, n + 1);
      chk(c_iec[33], n == 5);
      chk(c_iec[32:17], 16'h1237);
      if (n < 5) chk(c_iec[16:1], 16'(16'hFFFF << n));
      chk(c_iec[0], 1'b1);
      chk(dr, 1'b1);
      dr = 1'b0;
    end
    axi_wr(8'h08, 32'h0000_0000);
    axi_wr(8'h04, 32'h0000_0000);
    send_cmd(wcmd(3'b011));
    idle(12);
    chk(c_st, {64'h0000_0000_0100_0000, 32'hC0DE_0001});
    chk(ev_cnt, 1);
    axi_rd(8'h00, d, r);
    chk(d[0], 1'b1);
    send_cmd(wcmd(3'b001));
    idle(12);
    chk(st_cnt, 1);
    chk(ev_cnt, 1);
    axi_wr(8'h00, 32'h0000_0001);
    axi_wr(8'h04, 32'h8000_0000);
    send_cmd(wcmd(3'b001));
    idle(12);
    chk(ev_cnt, 1);
    axi_rd(8'h04, d, r);
    chk(d[30], 1'b1);
    axi_wr(8'h04, 32'h0000_0000);
    chk(ev_cnt, 2);
    // Slow endpoint keeps the wait open long enough to see it held
    slow <= 1'b1;
    send_cmd({64'h0000_0000_0040_0000, 60'h0, CMD_EP_INV});
    send_cmd(wcmd(3'b110));
    idle(3);
    chk(st_cnt, 1);
    chk(cmd_ready, 1'b0);
    idle(40);
    chk(st_cnt, 2);
    chk(cmd_ready, 1'b1);
    send_cmd(wcmd(3'b010));
    send_cmd(wcmd(3'b010));
    idle(40);
    chk(st_cnt, 4);
    axi_wr(8'h08, 32'h0000_0002);
    send_cmd({64'h0000_0000_0040_0000, 60'h1000, CMD_EP_INV});
    send_cmd({64'h0000_0000_0040_0000, 60'h0, CMD_EP_INV});
    idle(7);
    chk(ep_cnt, 8);
    send_cmd({64'h0000_0000_0040_0000, 60'h1000, CMD_EP_INV});
    idle(10);
    chk(ep_cnt, 8);
    idle(20);
    chk(ep_cnt, 9);
    end_sim();
  end
endmodule : ide_exec_bench
bind ide_exec ide_exec_checker chk_u (.clk_sys, .srst, .cmd_valid, .cmd_ready, .cmd_data, .ep_req_valid,
  .ep_req_ready, .ep_addr, .ep_range_log2, .wbuf_flush_req, .iec_inv_valid, .iec_global, .iec_index_care,
  .stat_wr_valid, .stat_wr_ready, .stat_wr_data, .wait_event);
`default_nettype wire

/* File: tb/ide_exec_checker.sv */
// Port-level assertions for the invalidation command executor
`default_nettype none
module ide_exec_checker
  import ide_pkg::*;
(
  // Clock and reset
  input wire logic         clk_sys,
  input wire logic         srst,
  // Command queue
  input wire logic         cmd_valid,
  input wire logic         cmd_ready,
  input wire logic [127:0] cmd_data,
  // Endpoint requests
  input wire logic         ep_req_valid,
  input wire logic         ep_req_ready,
  input wire logic [63:0]  ep_addr,
  input wire logic [5:0]   ep_range_log2,
  // Cache, flush and status
  input wire logic         wbuf_flush_req,
  input wire logic         iec_inv_valid,
  input wire logic         iec_global,
  input wire logic [15:0]  iec_index_care,
  input wire logic         stat_wr_valid,
  input wire logic         stat_wr_ready,
  input wire logic [31:0]  stat_wr_data,
  input wire logic         wait_event
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb_chk @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ****************************************
  // Last command and last wait seen
  // ****************************************
  logic [127:0] last_cmd;
  logic [31:0]  wait_data;
  logic [3:0]   mask_n;
  always_ff @(posedge clk_sys) begin
    if (cmd_valid && cmd_ready) begin
      last_cmd <= cmd_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (cmd_valid && cmd_ready && cmd_data[3:0] == CMD_WAIT) begin
      wait_data <= cmd_data[63:32];
    end
  end
  // Widths above four are clamped
  assign mask_n = (last_cmd[30:27] > 4'h4) ? 4'h4 : last_cmd[30:27];
  sequence s_ep_taken;
    cmd_valid && cmd_ready && cmd_data[3:0] == CMD_EP_INV;
  endsequence
  sequence s_fence_sw;
    cmd_valid && cmd_ready && cmd_data[3:0] == CMD_WAIT && cmd_data[6];
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  a_ep_dispatch: assert property (s_ep_taken |-> ##[2:40] ep_req_valid)
    else $error("endpoint command not issued");
  a_ep_hold: assert property (ep_req_valid && !ep_req_ready |=> ep_req_valid && $stable(ep_addr))
    else $error("endpoint request dropped or changed");
  a_page_single: assert property (ep_req_valid && !last_cmd[64] |-> ep_range_log2 == 6'h0C)
    else $error("single page range wrong");
  a_range_eight: assert property (ep_req_valid && last_cmd[64] && !last_cmd[76] |-> ep_range_log2 == 6'h0D)
    else $error("8KB range wrong");
  a_iec_scope: assert property (iec_inv_valid |-> iec_global == !last_cmd[4])
    else $error("cache invalidation scope wrong");
  a_iec_mask: assert property (iec_inv_valid && !iec_global |-> iec_index_care == 16'(16'hFFFF << mask_n))
    else $error("index mask wrong");
  a_flush_order: assert property (wbuf_flush_req |-> !iec_inv_valid)
    else $error("cache invalidated during flush");
  a_stat_data: assert property (stat_wr_valid |-> stat_wr_data == wait_data)
    else $error("status data wrong");
  a_stat_hold: assert property (stat_wr_valid && !stat_wr_ready |=> stat_wr_valid && $stable(stat_wr_data))
    else $error("status write dropped");
  a_event_pulse: assert property (wait_event |=> !wait_event)
    else $error("event longer than one cycle");
  a_fence_stall: assert property (s_fence_sw |=> !cmd_ready [*2])
    else $error("command taken behind fence");
endmodule : ide_exec_checker
`default_nettype wire

/* File: tb/ide_far_model.sv */
// Behavioural endpoints, flush, drain and memory side
`default_nettype none
module ide_far_model (
  // Clock, reset and pace
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic slow,
  // Endpoint requests
  input  wire logic ep_req_valid,
  output logic      ep_req_ready,
  output logic      ep_done,
  // Flush, drain and status write
  input  wire logic wbuf_flush_req,
  output logic      wbuf_flush_done,
  input  wire logic irq_drain_req,
  output logic      irq_drain_done,
  input  wire logic stat_wr_valid,
  output logic      stat_wr_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] pend;
  logic [3:0] wt;
  logic [3:0] tmr;
  logic       acc;
  // Slow mode stalls each endpoint request and status write handshake three cycles
  assign ep_req_ready  = ep_req_valid && (!slow || wt == 4'h3);
  assign stat_wr_ready = stat_wr_valid && (!slow || wt == 4'h3);
  assign acc           = ep_req_valid && ep_req_ready;
  assign ep_done       = pend != 6'h00 && tmr == (slow ? 4'hC : 4'h1);
  always_ff @(posedge clk_sys) begin
    if (srst || ep_req_ready || stat_wr_ready || !(ep_req_valid || stat_wr_valid)) begin
      wt <= 4'h0;
    end else begin
      wt <= wt + 4'h1;
    end
  end
  // Holds up to 63 pending, no backpressure
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pend <= 6'h00;
      tmr  <= 4'h0;
    end else begin
      pend <= pend + {5'h00, acc} - {5'h00, ep_done};
      tmr  <= (ep_done || pend == 6'h00) ? 4'h0 : tmr + 4'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wbuf_flush_done <= 1'b0;
      irq_drain_done  <= 1'b0;
    end else begin
      wbuf_flush_done <= wbuf_flush_req && !wbuf_flush_done;
      irq_drain_done  <= irq_drain_req && !irq_drain_done;
    end
  end
endmodule : ide_far_model
`default_nettype wire
